// ==== verilog/bit_shift_register.sv ====
// eight-stage single-bit shift register block
// Operation
// - each rising trigger edge samples the data bit and shifts once
// - a falling trigger edge changes nothing
// - direction low shifts upward, direction high shifts downward
// - upward: data enters first stage, others move up, last lost
// - downward: data enters last stage, others move down, first lost
// - output follows one stage chosen by a parameter, first to last
// - with retention all eight stages are kept together over power loss
// - without retention the register restarts from its initial state
`timescale 1ns/1ps
`include "shift_consts.svh"
module bit_shift_register #(
  parameter logic [`STAGE_IDX_W-1:0] OUTPUT_STAGE = 3'h0,
  parameter bit RETENTIVE = 1'b0
) (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_shift_trigger,
  input wire logic i_data_bit_source,
  input wire logic i_shift_direction,
  output logic o_selected_stage_output,
  output logic o_in_ready
);
  typedef struct packed {
    logic trig_prev;
    logic [`STAGE_COUNT-1:0] stages;
    logic sel_out;
    logic ready;
  } reg_state_type;
  reg_state_type st_q;
  reg_state_type st_d;
  shift_pkg::shift_req_type req_in;
  shift_pkg::shift_req_type req_out;
  logic rise;
  logic fifo_ready;
  logic out_valid;
  // requests queue through the fifo; its consumer is tied ready, so queued edges drain without a stall
  always_comb begin
    rise = i_shift_trigger && !st_q.trig_prev;
    req_in.data_bit = i_data_bit_source;
    req_in.shift_direction = i_shift_direction;
  end
  shift_fifo #(
    .WIDTH($bits(shift_pkg::shift_req_type)),
    .DEPTH(`FIFO_DEPTH)
  ) u_fifo (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_in_valid(rise),
    .o_in_ready(fifo_ready),
    .i_in_data(req_in),
    .o_out_valid(out_valid),
    .i_out_ready(1'b1),
    .o_out_data(req_out)
  );
  always_comb begin
    st_d = st_q;
    st_d.trig_prev = i_shift_trigger;
    st_d.ready = fifo_ready;
    if (out_valid) begin
      if (req_out.shift_direction == `DIR_UP) begin
        st_d.stages = {st_q.stages[`STAGE_COUNT-2:0],
                       req_out.data_bit};
      end else begin
        st_d.stages = {req_out.data_bit,
                       st_q.stages[`STAGE_COUNT-1:1]};
      end
    end
    st_d.sel_out = st_d.stages[OUTPUT_STAGE];
  end
  // retention keeps the whole stage vector as one unit; a reset then only
  // clears the edge tracker and the ready flag, which mimics a held backup of all stages
  generate
    if (RETENTIVE) begin : g_ret
      always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
          st_q.trig_prev <= 1'b0;
          st_q.ready <= 1'b0;
        end else begin
          st_q.trig_prev <= st_d.trig_prev;
          st_q.ready <= st_d.ready;
        end
      end
      always_ff @(posedge i_mclk) begin
        st_q.stages <= st_d.stages;
        st_q.sel_out <= st_d.sel_out;
      end
    end else begin : g_nret
      always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
          // constants only here: the reset branch must not read logic
          st_q <= '{trig_prev: 1'b0, stages: `STAGE_RESET,
                    sel_out: 1'b0, ready: 1'b0};
        end else begin
          st_q <= st_d;
        end
      end
    end
  endgenerate
  assign o_selected_stage_output = st_q.sel_out;
  assign o_in_ready = st_q.ready;
endmodule

// ==== verilog/shift_consts.svh ====
// constants for the eight-stage bit shift register
`ifndef SHIFT_CONSTS_SVH
`define SHIFT_CONSTS_SVH
`define STAGE_COUNT 8
`define STAGE_IDX_W 3
`define STAGE_RESET 8'h00
`define FIFO_DEPTH 8
`define FIFO_PTR_W 3
`define FIFO_CNT_W 4
`define DIR_UP 1'h0
`endif

// ==== verilog/shift_pkg.sv ====
// types shared by the shift register design
package shift_pkg;
  typedef struct packed {
    logic data_bit;
    logic shift_direction;
  } shift_req_type;
endpackage

// ==== verilog/shift_fifo.sv ====
// small valid/ready fifo with registered read data
`timescale 1ns/1ps
module shift_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 8
) (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
    logic out_valid;
    logic [WIDTH-1:0] out_data;
  } fifo_state_type;
  fifo_state_type st_q;
  fifo_state_type st_d;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic push;
  logic pop;
  logic load;
  always_comb begin
    push = i_in_valid && (st_q.count != (PW+1)'(DEPTH));
    // output register refills whenever it is empty or being consumed and the fifo holds an entry
    load = (st_q.count != '0) && (!st_q.out_valid || i_out_ready);
    pop = load;
    st_d = st_q;
    if (push) begin
      st_d.wr_ptr = st_q.wr_ptr + 1'b1;
    end
    if (pop) begin
      st_d.rd_ptr = st_q.rd_ptr + 1'b1;
      st_d.out_data = mem_q[st_q.rd_ptr];
      st_d.out_valid = 1'b1;
    end else if (i_out_ready) begin
      st_d.out_valid = 1'b0;
    end
    st_d.count = st_q.count + (PW+1)'(push) - (PW+1)'(pop);
  end
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem_q[st_q.wr_ptr] <= i_in_data;
    end
  end
  assign o_in_ready = (st_q.count != (PW+1)'(DEPTH));
  assign o_out_valid = st_q.out_valid;
  assign o_out_data = st_q.out_data;
endmodule

// ==== test/shift_properties.sv ====
// assertion checker for the bit shift register ports
`timescale 1ns/1ps
module shift_properties #(
  parameter logic [2:0] OUTPUT_STAGE = 3'h0
) (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_shift_trigger,
  input wire logic i_data_bit_source,
  input wire logic i_shift_direction,
  input wire logic o_selected_stage_output,
  input wire logic o_in_ready
);
  logic tr_q;
  logic [7:0] m_q;
  wire take = i_shift_trigger & ~tr_q;
  wire o = o_selected_stage_output;
  // reference stages, updated at the taking edge
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      tr_q <= 1'b0;
      m_q <= 8'h00;
    end else begin
      tr_q <= i_shift_trigger;
      if (take)
        m_q <= i_shift_direction ? {i_data_bit_source, m_q[7:1]}
          : {m_q[6:0], i_data_bit_source};
    end
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  // the model updates one edge after the take, the output three edges after
  track_out_a: assert property (o == $past(m_q[OUTPUT_STAGE], 2))
    else $error("track");
  up_one_a: assert property (
    take && !i_shift_direction && i_data_bit_source |-> ##3 o)
    else $error("up one");
  up_zero_a: assert property (
    take && !i_shift_direction && !i_data_bit_source |-> ##3 !o)
    else $error("up zero");
  // stage index 0 assumed: a down shift brings in the second stage
  down_a: assert property (
    take && i_shift_direction |-> ##3 o == $past(m_q[1], 3))
    else $error("down");
  quiet_a: assert property (!$past(take, 3) |-> $stable(o))
    else $error("quiet");
  rst_clear_a: assert property ($rose(i_nrst) |-> !o)
    else $error("reset");
  ready_hi_a: assert property ($past(i_nrst, 2) |-> o_in_ready)
    else $error("ready");
  // a second take on the held level would move the output after the fourth
  held_once_a: assert property (
    take ##1 i_shift_trigger [*3] |-> ##1 $stable(o))
    else $error("held");
  cover property (take && i_shift_direction);
  cover property (take && !i_shift_direction);
  cover property ($fell(i_shift_trigger));
endmodule

// ==== test/shift_src.sv ====
// partner logic block driving trigger, data and direction
`timescale 1ns/1ps
module shift_src (
  input wire logic i_mclk,
  output logic o_trg = 1'b0,
  output logic o_dat = 1'b0,
  output logic o_dir = 1'b0
);
  // one source only, as the block may appear once
  task pulse(input logic d, input logic r, input int hi);
    @(posedge i_mclk);
    o_trg <= 1'b1;
    o_dat <= d;
    o_dir <= r;
    repeat (hi) @(posedge i_mclk);
    o_trg <= 1'b0;
  endtask
endmodule

// ==== test/tb.sv ====
// testbench for the bit shift register
`timescale 1ns/1ps
module tb;
  logic i_mclk = 1'b0;
  logic i_nrst = 1'b0;
  logic trg, dat, dir, q, rdy;
  int miscompares = 0;
  int total_checks = 0;
  always #5 i_mclk = ~i_mclk;
  shift_src u_src (.i_mclk(i_mclk), .o_trg(trg), .o_dat(dat), .o_dir(dir));
  bit_shift_register u_dut (.i_mclk(i_mclk), .i_nrst(i_nrst),
    .i_shift_trigger(trg), .i_data_bit_source(dat),
    .i_shift_direction(dir), .o_selected_stage_output(q), .o_in_ready(rdy));
  task chk(input logic s, input logic e);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %0t output mismatch", $time);
    end
  endtask
  task finish_test;
    $display("checks %0d errors %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // shift once, then wait out the three-cycle answer
  task sh(input logic d, input logic r, input int hi);
    u_src.pulse(d, r, hi);
    repeat (4) @(posedge i_mclk);
    #1;
  endtask
  task down_case;
    sh(1'b1, 1'b1, 1);
    chk(rdy, 1'b1);
    repeat (6) sh(1'b0, 1'b1, 1);
    chk(q, 1'b0);
    sh(1'b0, 1'b1, 1);
    chk(q, 1'b1);
    sh(1'b0, 1'b1, 1);
    chk(q, 1'b0);
  endtask
  task up_case;
    sh(1'b1, 1'b0, 1);
    chk(q, 1'b1);
    sh(1'b0, 1'b0, 1);
    chk(q, 1'b0);
  endtask
  // a long high trigger must count once; a repeat would bring in a zero
  task hold_case;
    sh(1'b0, 1'b1, 20);
    chk(q, 1'b1);
    repeat (6) @(posedge i_mclk);
    chk(q, 1'b1);
  endtask
  task reset_case;
    @(posedge i_mclk);
    i_nrst <= 1'b0;
    repeat (10) @(posedge i_mclk);
    i_nrst <= 1'b1;
    #1;
    chk(q, 1'b0);
  endtask
  initial begin
    repeat (10) @(posedge i_mclk);
    i_nrst <= 1'b1;
    #1;
    chk(q, 1'b0);
    down_case();
    up_case();
    hold_case();
    reset_case();
    finish_test();
  end
endmodule
bind bit_shift_register shift_properties #(.OUTPUT_STAGE(OUTPUT_STAGE))
  u_props (.i_mclk(i_mclk), .i_nrst(i_nrst),
  .i_shift_trigger(i_shift_trigger), .i_data_bit_source(i_data_bit_source),
  .i_shift_direction(i_shift_direction), .o_in_ready(o_in_ready),
  .o_selected_stage_output(o_selected_stage_output));
